// ==== verilog/rps_pkg.sv ====
// Package of constants for the RF path select chain controller.
// Assumes a 40 MHz system clock and a simple strobe register port.
package rps_pkg;

	// System clock period in picoseconds.
	localparam int CLK_PERIOD_PS = 25000;

	// Fastest serial clock the switch units accept, in MHz.
	localparam int SCLK_MAX_MHZ = 20;
	// Shortest serial clock period in picoseconds, derived from the rate.
	localparam int SCLK_MIN_PERIOD_PS = 1000000 / SCLK_MAX_MHZ;
	// Least high and low times of the serial clock, in nanoseconds.
	localparam int SCLK_HIGH_MIN_NS = 8;
	localparam int SCLK_LOW_MIN_NS = 14;
	// Least latch gate pulse width and setup after the last rise, in ns.
	localparam int GATE_PULSE_MIN_NS = 8;
	localparam int GATE_SETUP_MIN_NS = 8;

	// Least times rounded up to whole system clock cycles.
	localparam int SCLK_HALF_CYC =
		(SCLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SCLK_HIGH_CYC =
		(SCLK_HIGH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SCLK_LOW_CYC =
		(SCLK_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GATE_PULSE_CYC =
		(GATE_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GATE_SETUP_CYC =
		(GATE_SETUP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Returns the larger of two counts.
	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// One divider step covers every least phase time at once.
	localparam int PHASE_CYC = max2(max2(SCLK_HALF_CYC, SCLK_HIGH_CYC),
		max2(max2(SCLK_LOW_CYC, GATE_PULSE_CYC), GATE_SETUP_CYC));

	// Divider counter width and its terminal count.
	localparam int TICK_W = 4;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(PHASE_CYC - 1);

	// Chain size: units held in the selection memory.
	localparam int UNIT_W = 4;
	localparam int MAX_UNITS = 16;
	// Throw index width: 0 means the first throw, 7 the eighth.
	localparam int THROW_W = 3;
	// Select bits sent per unit.
	localparam int SEL_BITS = 4;
	localparam logic [1:0] SEL_LAST = 2'h3;

	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_UNITS = 8'h08;
	// Selection window: one word per unit from this base.
	localparam logic [1:0] WIN_TOP = 2'h1;

	// Control register fields and reset values.
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam logic CTRL_HOLD_RST = 1'b1;
	// Status register fields.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;

	// Engine states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_LOAD  = 3'h1,
		ST_FETCH = 3'h2,
		ST_SLOW  = 3'h3,
		ST_SHIGH = 3'h4,
		ST_SGAP  = 3'h5,
		ST_SETUP = 3'h6,
		ST_GATE  = 3'h7
	} rps_state_t;

endpackage

// ==== verilog/rps_tick.sv ====
// Phase divider that paces the serial clock and latch gate.
// Assumes the caller holds i_run high for as long as a phase sequence lasts.
`timescale 1ns/1ps
`default_nettype none
module rps_tick (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_run,
	output logic o_tick
);

	// Cycle counter within the present phase.
	logic [rps_pkg::TICK_W-1:0] cnt_reg;

	// The tick marks the last cycle of a phase.
	assign o_tick = i_run && (cnt_reg == rps_pkg::TICK_LAST);

	// Counts while running and restarts at every tick or when stopped.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_reg <= '0;
		end else if (i_ce) begin
			if (!i_run || o_tick) begin
				cnt_reg <= '0;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

endmodule // rps_tick
`default_nettype wire

// ==== verilog/rps_selmem.sv ====
// Small memory of throw selections, one entry per chained unit.
// Assumes one write port and one read port with a registered output.
`timescale 1ns/1ps
`default_nettype none
module rps_selmem (
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_we,
	input wire logic [rps_pkg::UNIT_W-1:0] i_waddr,
	input wire logic [rps_pkg::THROW_W-1:0] i_wdata,
	input wire logic [rps_pkg::UNIT_W-1:0] i_raddr,
	output logic [rps_pkg::THROW_W-1:0] o_rdata
);

	// Storage array; contents are undefined until software writes them.
	logic [rps_pkg::THROW_W-1:0] mem [rps_pkg::MAX_UNITS];

	// Writes and registered reads, both frozen while the enable is low.
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (i_we) begin
				mem[i_waddr] <= i_wdata;
			end
			o_rdata <= mem[i_raddr];
		end
	end

endmodule // rps_selmem
`default_nettype wire

// ==== verilog/rps_ctrl.sv ====
// Controller for a daisy chain of serially loaded eight-throw RF switches.
// Assumes a 40 MHz clock, a strobe register port and switch units on pins.
`timescale 1ns/1ps
`default_nettype none
module rps_ctrl (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [rps_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rps_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [rps_pkg::DATA_W-1:0] o_rdata,
	output logic o_sdata,
	output logic o_sclk,
	output logic o_latch_gate,
	output logic o_hold
);

	// Engine state and its next value.
	rps_pkg::rps_state_t state_reg;
	rps_pkg::rps_state_t state_next;
	// Unit being sent; counts down from the farthest unit.
	logic [rps_pkg::UNIT_W-1:0] unit_reg;
	// Bit position within the present unit.
	logic [1:0] bit_reg;
	// Select bits of the present unit still to send, the next one in the low position.
	logic [rps_pkg::SEL_BITS-1:0] shift_reg;
	// Number of chained units minus one.
	logic [rps_pkg::UNIT_W-1:0] units_reg;
	// Hold level driven to the chain.
	logic hold_reg;
	// Completion flag, sticky until software clears it.
	logic done_reg;
	// Pin registers.
	logic sdata_reg;
	logic sclk_reg;
	logic gate_reg;
	// Register read data and a flag saying a window read is pending.
	logic [rps_pkg::DATA_W-1:0] rdata_reg;
	logic win_rd_reg;

	// Decoded register accesses.
	wire logic busy = (state_reg != rps_pkg::ST_IDLE);
	wire logic hit_ctrl = (i_addr == rps_pkg::ADDR_CTRL);
	wire logic hit_status = (i_addr == rps_pkg::ADDR_STATUS);
	wire logic hit_units = (i_addr == rps_pkg::ADDR_UNITS);
	wire logic hit_win = (i_addr[7:6] == rps_pkg::WIN_TOP) &&
		(i_addr[1:0] == 2'h0);
	wire logic [rps_pkg::UNIT_W-1:0] win_idx = i_addr[5:2];
	wire logic go = i_wr && hit_ctrl && i_wdata[rps_pkg::CTRL_GO_BIT] &&
		!busy;
	wire logic done_clr = i_wr && hit_status &&
		i_wdata[rps_pkg::STAT_DONE_BIT];
	// Selections may only change while the engine is idle.
	wire logic mem_we = i_wr && hit_win && !busy;

	// Memory read port: the engine owns it while busy.
	wire logic [rps_pkg::UNIT_W-1:0] mem_raddr = busy ? unit_reg : win_idx;
	wire logic [rps_pkg::THROW_W-1:0] mem_rdata;

	// Divider pacing and its run condition.
	wire logic tick;
	wire logic tick_run = (state_reg == rps_pkg::ST_SLOW) ||
		(state_reg == rps_pkg::ST_SHIGH) ||
		(state_reg == rps_pkg::ST_SETUP) ||
		(state_reg == rps_pkg::ST_GATE);

	// Encoding of a throw index into the four select bits.
	wire logic [1:0] grp_pos = mem_rdata[1:0];
	wire logic sel_b0 = !mem_rdata[2];
	wire logic sel_b1 = 1'b0;
	wire logic sel_b2 = !grp_pos[1];
	wire logic sel_b3 = grp_pos[1] ^ grp_pos[0];
	wire logic [rps_pkg::SEL_BITS-1:0] sel_word =
		{sel_b3, sel_b2, sel_b1, sel_b0};

	// Bookkeeping for the end of a unit and of the chain.
	wire logic last_bit = (bit_reg == rps_pkg::SEL_LAST);
	wire logic last_unit = (unit_reg == '0);

	// Read data for the plain registers.
	wire logic [rps_pkg::DATA_W-1:0] rd_ctrl =
		{{(rps_pkg::DATA_W-2){1'b0}}, hold_reg, 1'b0};
	wire logic [rps_pkg::DATA_W-1:0] rd_status =
		{{(rps_pkg::DATA_W-2){1'b0}}, done_reg, busy};
	wire logic [rps_pkg::DATA_W-1:0] rd_units =
		{{(rps_pkg::DATA_W-rps_pkg::UNIT_W){1'b0}}, units_reg};
	wire logic [rps_pkg::DATA_W-1:0] rd_mux =
		hit_ctrl ? rd_ctrl :
		hit_status ? rd_status :
		hit_units ? rd_units : '0;

	// Phase divider shared by clock phases, gate setup and gate pulse.
	rps_tick u_tick (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_run(tick_run),
		.o_tick(tick)
	);

	// Throw selections for every unit of the chain.
	rps_selmem u_selmem (
		.i_clk(i_clk),
		.i_ce(i_ce),
		.i_we(mem_we),
		.i_waddr(win_idx),
		.i_wdata(i_wdata[rps_pkg::THROW_W-1:0]),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);

	// Window reads while idle come from the memory register, others from rdata_reg.
	assign o_rdata = win_rd_reg ?
		{{(rps_pkg::DATA_W-rps_pkg::THROW_W){1'b0}}, mem_rdata} : rdata_reg;
	assign o_sdata = sdata_reg;
	assign o_sclk = sclk_reg;
	assign o_latch_gate = gate_reg;
	assign o_hold = hold_reg;

	// Next state of the load engine.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// Waits for software to start a load.
			rps_pkg::ST_IDLE: begin
				if (go) begin
					state_next = rps_pkg::ST_LOAD;
				end
			end
			// Presents the unit number to the memory.
			rps_pkg::ST_LOAD: begin
				state_next = rps_pkg::ST_FETCH;
			end
			// Takes the encoded bits and puts out the first one.
			rps_pkg::ST_FETCH: begin
				state_next = rps_pkg::ST_SLOW;
			end
			// Serial clock low with data settling.
			rps_pkg::ST_SLOW: begin
				if (tick) begin
					state_next = rps_pkg::ST_SHIGH;
				end
			end
			// Serial clock high; the far end samples on entry.
			rps_pkg::ST_SHIGH: begin
				if (tick) begin
					if (!last_bit) begin
						state_next = rps_pkg::ST_SGAP;
					end else if (!last_unit) begin
						state_next = rps_pkg::ST_LOAD;
					end else begin
						state_next = rps_pkg::ST_SETUP;
					end
				end
			end
			// One cycle after the fall before data may change.
			rps_pkg::ST_SGAP: begin
				state_next = rps_pkg::ST_SLOW;
			end
			// Gate setup time after the last rising edge.
			rps_pkg::ST_SETUP: begin
				if (tick) begin
					state_next = rps_pkg::ST_GATE;
				end
			end
			// Gate high pulse, then back to idle.
			rps_pkg::ST_GATE: begin
				if (tick) begin
					state_next = rps_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = rps_pkg::ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= rps_pkg::ST_IDLE;
		end else if (i_ce) begin
			state_reg <= state_next;
		end
	end

	// Unit and bit counters: farthest unit first, bit 0 first.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			unit_reg <= '0;
			bit_reg <= '0;
		end else if (i_ce) begin
			if (go) begin
				unit_reg <= units_reg;
			end else if (state_reg == rps_pkg::ST_FETCH) begin
				bit_reg <= '0;
			end else if (state_reg == rps_pkg::ST_SGAP) begin
				bit_reg <= bit_reg + 1'b1;
			end else if (state_reg == rps_pkg::ST_SHIGH && tick &&
				last_bit && !last_unit) begin
				unit_reg <= unit_reg - 1'b1;
			end
		end
	end

	// Select bit shifter and serial data pin.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			shift_reg <= '0;
			sdata_reg <= 1'b0;
		end else if (i_ce) begin
			if (state_reg == rps_pkg::ST_FETCH) begin
				// Four bits per unit, bit 0 leads.
				shift_reg <= sel_word >> 1;
				sdata_reg <= sel_word[0];
			end else if (state_reg == rps_pkg::ST_SGAP) begin
				// Data moves a cycle after the fall, keeping hold time.
				shift_reg <= shift_reg >> 1;
				sdata_reg <= shift_reg[0];
			end
		end
	end

	// Serial clock pin, paced by the phase divider.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sclk_reg <= 1'b0;
		end else if (i_ce) begin
			if (state_reg == rps_pkg::ST_SLOW && tick) begin
				sclk_reg <= 1'b1;
			end else if (state_reg == rps_pkg::ST_SHIGH && tick) begin
				sclk_reg <= 1'b0;
			end
		end
	end

	// Latch gate pin: low while shifting, one pulse after the chain.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			gate_reg <= 1'b0;
		end else if (i_ce) begin
			if (state_reg == rps_pkg::ST_SETUP && tick) begin
				gate_reg <= 1'b1;
			end else if (state_reg == rps_pkg::ST_GATE && tick) begin
				gate_reg <= 1'b0;
			end
		end
	end

	// Software registers: hold level, unit count and done flag.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hold_reg <= rps_pkg::CTRL_HOLD_RST;
			units_reg <= '0;
			done_reg <= 1'b0;
		end else if (i_ce) begin
			if (i_wr && hit_ctrl) begin
				hold_reg <= i_wdata[rps_pkg::CTRL_HOLD_BIT];
			end
			if (i_wr && hit_units && !busy) begin
				units_reg <= i_wdata[rps_pkg::UNIT_W-1:0];
			end
			// Completion sets the flag and wins over a clear.
			if (state_reg == rps_pkg::ST_GATE && tick) begin
				done_reg <= 1'b1;
			end else if (done_clr) begin
				done_reg <= 1'b0;
			end
		end
	end

	// Read data register, valid in the cycle after the strobe only.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= '0;
			win_rd_reg <= 1'b0;
		end else if (i_ce) begin
			rdata_reg <= i_rd ? rd_mux : '0;
			win_rd_reg <= i_rd && hit_win && !busy;
		end
	end

endmodule // rps_ctrl
`default_nettype wire

// ==== bench/rps_ctrl_monitor.sv ====
// Checker for the serial path select controller's pin timing.
// Assumes it is bound to rps_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rps_ctrl_monitor (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [rps_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rps_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [rps_pkg::DATA_W-1:0] o_rdata,
	input wire logic o_sdata,
	input wire logic o_sclk,
	input wire logic o_latch_gate,
	input wire logic o_hold
);
	// All checks use the system clock and rest while reset is high.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_sclk_high: assert property ($rose(o_sclk) |=> !o_sclk)
		else $error("Serial clock high for more than one cycle.");
	a_sclk_low: assert property ($fell(o_sclk) |=> !o_sclk)
		else $error("Serial clock low for less than two cycles.");
	a_data_setup: assert property ($rose(o_sclk) |-> $stable(o_sdata))
		else $error("Serial data changed with the clock rise.");
	a_data_hold: assert property ($fell(o_sclk) |-> $stable(o_sdata))
		else $error("Serial data changed with the clock fall.");
	a_gate_quiet: assert property (o_latch_gate |-> !o_sclk)
		else $error("Serial clock active while the gate is open.");
	a_gate_pulse: assert property ($rose(o_latch_gate) |=> !o_latch_gate)
		else $error("Latch gate pulse is not one cycle long.");
	a_gate_setup: assert property ($rose(o_latch_gate) |->
		$past(o_sclk, 2) && !$past(o_sclk))
		else $error("Latch gate rose too soon after the last clock rise.");
	a_hold_write: assert property (i_wr && i_ce &&
		i_addr == rps_pkg::ADDR_CTRL |=>
		o_hold == $past(i_wdata[rps_pkg::CTRL_HOLD_BIT]))
		else $error("Hold pin does not follow the control write.");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
		else $error("Read data present without a read.");
	a_ce_freeze: assert property (!i_ce |=> $stable(o_sclk) &&
		$stable(o_latch_gate) && $stable(o_hold) && $stable(o_sdata))
		else $error("Pins moved while the clock enable was low.");
endmodule // rps_ctrl_monitor

bind rps_ctrl rps_ctrl_monitor i_mon (.i_clk(i_clk), .i_rst(i_rst),
	.i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_sdata(o_sdata), .o_sclk(o_sclk),
	.o_latch_gate(o_latch_gate), .o_hold(o_hold));
`default_nettype wire

// ==== bench/rps_switch_chain.sv ====
// Behavioural chain of serially loaded eight-throw switch units.
// Assumes unit 0 is nearest the controller and takes the data first.
`timescale 1ns/1ps
`default_nettype none
module rps_switch_chain #(
	parameter int NUM_UNITS = 3
) (
	input wire logic i_sdata,
	input wire logic i_sclk,
	input wire logic i_latch_gate,
	input wire logic i_hold,
	output logic [4*NUM_UNITS-1:0] o_throw
);
	// Four shift stages per unit; stage 3 feeds the next unit.
	logic [3:0] shift_reg [NUM_UNITS];
	// Latched select bits that set each unit's switch.
	logic [3:0] latch_reg [NUM_UNITS];

	// Each clock rise moves the whole chain one place, whatever the gate.
	always @(posedge i_sclk) begin
		shift_reg[0] <= {shift_reg[0][2:0], i_sdata};
		for (int k = 1; k < NUM_UNITS; k++) begin
			shift_reg[k] <= {shift_reg[k][2:0], shift_reg[k-1][3]};
		end
	end

	// The gate reaches every unit at once; the latch is open only
	// while gate and hold are both high and keeps its value otherwise.
	always @(*) begin
		for (int k = 0; k < NUM_UNITS; k++) begin
			if (i_latch_gate && i_hold) begin
				latch_reg[k] = shift_reg[k];
			end
		end
	end

	// Top bit flags a set select bit 1; low bits give the throw 0..7.
	always @(*) begin
		for (int k = 0; k < NUM_UNITS; k++) begin
			o_throw[4*k +: 4] = {latch_reg[k][2], ~latch_reg[k][3],
				~latch_reg[k][1], latch_reg[k][1] ^ ~latch_reg[k][0]};
		end
	end
endmodule // rps_switch_chain
`default_nettype wire

// ==== bench/rps_ctrl_tb_top.sv ====
// Self-checking bench for the serial path select controller.
// Assumes the controller, its checker and the chain model compile first.
`timescale 1ns/1ps
`default_nettype none
module rps_ctrl_tb_top;
	// Units in the modelled chain.
	localparam int NUNITS = 3;
	logic clk;
	logic rst;
	logic ce;
	logic [rps_pkg::ADDR_W-1:0] addr;
	logic [rps_pkg::DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic [rps_pkg::DATA_W-1:0] rdata;
	logic sdata;
	logic sclk;
	logic gate;
	logic hold;
	logic [4*NUNITS-1:0] throws;
	logic [rps_pkg::DATA_W-1:0] rdv;
	int num_errors;
	int tests_run;

	rps_ctrl i_dut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_sdata(sdata), .o_sclk(sclk), .o_latch_gate(gate), .o_hold(hold));
	rps_switch_chain #(.NUM_UNITS(NUNITS)) i_chain (.i_sdata(sdata),
		.i_sclk(sclk), .i_latch_gate(gate), .i_hold(hold), .o_throw(throws));

	// The 40 MHz system clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Prints the verdict and ends the run.
	task automatic final_report();
		if (num_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Compares a register word.
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares one unit's decoded switch state.
	task automatic chk_throw(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe.
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// One-cycle read strobe; data are taken in the following cycle.
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	// Reads a register and compares it.
	task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus_rd(a, d);
		chk_reg(d, exp);
	endtask

	// Polls the done flag under a bound, then clears it.
	task automatic wait_done();
		int n;
		n = 0;
		rdv = '0;
		while (rdv[rps_pkg::STAT_DONE_BIT] !== 1'b1) begin
			bus_rd(rps_pkg::ADDR_STATUS, rdv);
			n++;
			if (n > 100) begin
				num_errors++;
				final_report();
			end
		end
		bus_wr(rps_pkg::ADDR_STATUS, 32'h00000002);
	endtask

	// Main sequence.
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		num_errors = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Reset values and an unmapped address.
		read_chk(rps_pkg::ADDR_CTRL, 32'h00000002);
		read_chk(rps_pkg::ADDR_STATUS, 32'h00000000);
		read_chk(rps_pkg::ADDR_UNITS, 32'h00000000);
		read_chk(8'h0C, 32'h00000000);
		// A start with the clock enable low is not taken.
		@(posedge clk);
		ce <= 1'b0;
		bus_wr(rps_pkg::ADDR_CTRL, 32'h00000001);
		ce <= 1'b1;
		read_chk(rps_pkg::ADDR_CTRL, 32'h00000002);
		read_chk(rps_pkg::ADDR_STATUS, 32'h00000000);
		bus_wr(rps_pkg::ADDR_UNITS, 32'(NUNITS - 1));
		// Every throw code reaches every unit of the chain.
		for (int t = 0; t < 8; t++) begin
			for (int u = 0; u < NUNITS; u++) begin
				bus_wr(8'h40 + 8'(4 * u), 32'((t + 3 * u) % 8));
			end
			bus_wr(rps_pkg::ADDR_CTRL, 32'h00000003);
			read_chk(rps_pkg::ADDR_STATUS, 32'h00000001);
			// Selection writes are dropped while the chain loads.
			bus_wr(8'h40, 32'(t ^ 1));
			read_chk(8'h40, 32'h00000000);
			// A unit count written while the chain loads is dropped too.
			bus_wr(rps_pkg::ADDR_UNITS, 32'h0000000F);
			wait_done();
			read_chk(rps_pkg::ADDR_STATUS, 32'h00000000);
			read_chk(rps_pkg::ADDR_UNITS, 32'(NUNITS - 1));
			read_chk(8'h40, 32'(t));
			for (int u = 0; u < NUNITS; u++) begin
				chk_throw(throws[4*u +: 4], 4'((t + 3 * u) % 8));
			end
		end
		// With hold low unit 0 keeps its state.
		bus_wr(8'h40, 32'h00000004);
		bus_wr(rps_pkg::ADDR_CTRL, 32'h00000001);
		wait_done();
		read_chk(rps_pkg::ADDR_CTRL, 32'h00000000);
		chk_throw(throws[3:0], 4'h7);
		// Raising hold alone leaves the latch closed.
		bus_wr(rps_pkg::ADDR_CTRL, 32'h00000002);
		// Let the hold pin settle high before looking at the unit.
		@(negedge clk);
		chk_throw(throws[3:0], 4'h7);
		bus_wr(rps_pkg::ADDR_CTRL, 32'h00000003);
		wait_done();
		chk_throw(throws[3:0], 4'h4);
		chk_throw(throws[7:4], 4'h2);
		final_report();
	end
endmodule // rps_ctrl_tb_top
`default_nettype wire
